//--- pss_pkg.sv
// Package for the summary status block: register map, field positions and event layout.
// Assumes an APB master with 32-bit data and word-aligned registers.
package pss_pkg;
  // Printed offsets include values that are not multiples of four, so they are indices; byte address is four times.
  localparam logic [7:0] PSS_IDX_BSR = 8'h01;
  localparam logic [7:0] PSS_IDX_NER = 8'h06;
  localparam logic [7:0] PSS_IDX_SUM = 8'h10;
  localparam logic [7:0] PSS_IDX_FCC = 8'h14;
  localparam logic [7:0] PSS_IDX_REC = 8'h15;
  localparam logic [7:0] PSS_IDX_TEN = 8'h1a;
  localparam logic [7:0] PSS_IDX_CTL = 8'h30;
  localparam logic [7:0] PSS_IDX_IST = 8'h31;
  localparam logic [7:0] PSS_IDX_IMK = 8'h32;
  localparam logic [7:0] PSS_IDX_SIG = 8'h33;
  localparam int PSS_BYTE_SHIFT = 2;
  localparam int PSS_ADDR_W = 10;
  // Summary register field positions.
  localparam int PSS_B_RSV15 = 15;
  localparam int PSS_B_XOVER = 14;
  localparam int PSS_B_RXERR = 13;
  localparam int PSS_B_POL = 12;
  localparam int PSS_B_FCAR = 11;
  localparam int PSS_B_SDET = 10;
  localparam int PSS_B_LOCK = 9;
  localparam int PSS_B_PAGE = 8;
  localparam int PSS_B_RSV7 = 7;
  localparam int PSS_B_RFLT = 6;
  localparam int PSS_B_JAB = 5;
  // Source register bits that the summary copies.
  localparam int PSS_B_TEN_POL = 4;
  localparam int PSS_B_NER_PAGE = 1;
  localparam int PSS_B_BSR_RFLT = 4;
  localparam int PSS_B_BSR_JAB = 1;
  // Control register fields.
  localparam int PSS_B_CTL_AXEN = 0;
  localparam int PSS_B_CTL_XFRC = 1;
  localparam int PSS_B_CTL_SDQ = 2;
  localparam logic [2:0] PSS_CTL_RST = 3'h1;
  localparam int PSS_NEV = 8;
  localparam int PSS_CNT_W = 8;
  localparam logic [31:0] PSS_RD_ZERO = 32'h0;

  // Raw status inputs from the physical layer, not yet on the pclk domain.
  typedef struct packed {
    logic xover_swap;
    logic rx_error;
    logic false_carrier;
    logic polarity_inv;
    logic raw_sd;
    logic lock;
    logic page_rx;
    logic remote_fault;
    logic jabber;
  } pss_phy_t;

  // Clearing reads of the source registers, one-cycle pulses.
  typedef struct packed {
    logic bsr;
    logic ner;
    logic fcc;
    logic rec;
    logic ten;
  } pss_rdclr_t;
endpackage

//--- pss_stat_cell.sv
// One latched status cell, latch-high or latch-low, with a clearing read.
// Assumes the event input is already synchronous to pclk.
module pss_stat_cell #(
  parameter bit LATCH_LOW = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cond,
  input wire logic clr,
  output logic q_r
);
  // Latch-low cells rest at zero until the first clearing read arms them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= 1'b0;
    end else if (LATCH_LOW) begin
      // A drop in the same cycle as the read stays visible.
      if (!cond) begin
        q_r <= 1'b0; // see R13
      end else if (clr) begin
        q_r <= 1'b1;
      end
    end else begin
      // An event in the same cycle as the clearing read wins.
      if (cond) begin
        q_r <= 1'b1; // see R13
      end else if (clr) begin
        q_r <= 1'b0;
      end
    end
  end
endmodule

//--- pss_summary.sv
// Summary status register block with its source registers and an interrupt.
// Assumes an APB master on pclk and status inputs that come from outside the domain.
// Operation
// R1: Bits 15 and 7 read zero and ignore writes.
// R2: Bit 14 shows swapped pairs as one, normal pairs as zero.
// R3: Pair bit follows crossover enable, force, and the automatic swaps.
// R4: Bit 13 latches receive errors until the error counter register is read.
// R5: Bit 12 mirrors the 10 Mb/s polarity flag, cleared by that register's read.
// R6: Bit 11 latches false carrier until the false carrier counter is read.
// R7: Bit 10 is qualified signal detect, optionally ANDed with lock, latch low.
// R8: Bit 9 is descrambler lock, latching low until read.
// R9: Bit 8 copies page received, cleared only by reading the expansion register.
// R10: Bit 6 sets on remote fault, clears on basic status read or reset.
// R11: Bit 5 copies jabber, unchanged by summary reads.
// R12: Summary register sits at index 10h.
// R13: Latched bits hold until their clearing read.
module pss_summary (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pss_pkg::PSS_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire pss_pkg::pss_phy_t phy_in,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq
);
  import pss_pkg::*;

  pss_phy_t s1_r;
  pss_phy_t ps_r;
  logic [2:0] ctl_r;
  logic [PSS_NEV-1:0] ist_r;
  logic [PSS_NEV-1:0] imk_r;
  logic [PSS_NEV-1:0] ev_nxt;
  logic [PSS_CNT_W-1:0] rec_cnt_r;
  logic [PSS_CNT_W-1:0] fcc_cnt_r;
  logic rxerr_d_r;
  logic fcar_d_r;
  logic xover_d_r;
  logic lock_d_r;
  logic ok_nxt;
  logic acc;
  logic rd;
  logic wr;
  logic [7:0] idx;
  pss_rdclr_t rc;
  logic rxe_ev;
  logic fcar_ev;
  logic qsd;
  logic xover;
  logic l_rxerr, l_fcar, l_pol, l_sd, l_lock, l_page, l_rflt, l_jab;
  logic [15:0] sum;
  logic [31:0] rd_nxt;

  // Two flops on every status input since they come from the line side.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= '0;
      ps_r <= '0;
    end else begin
      s1_r <= phy_in;
      ps_r <= s1_r;
    end
  end

  assign acc = psel && penable;
  assign idx = paddr[PSS_ADDR_W-1:PSS_BYTE_SHIFT];
  assign rd = acc && !pwrite && pready;
  assign wr = acc && pwrite && pready;
  assign rc.bsr = rd && (idx == PSS_IDX_BSR);
  assign rc.ner = rd && (idx == PSS_IDX_NER);
  assign rc.fcc = rd && (idx == PSS_IDX_FCC);
  assign rc.rec = rd && (idx == PSS_IDX_REC);
  assign rc.ten = rd && (idx == PSS_IDX_TEN);

  // Receive errors and false carriers count once per rising edge of the event.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxerr_d_r <= 1'b0;
      fcar_d_r <= 1'b0;
      xover_d_r <= 1'b0;
      lock_d_r <= 1'b0;
    end else begin
      rxerr_d_r <= ps_r.rx_error;
      fcar_d_r <= ps_r.false_carrier;
      xover_d_r <= xover;
      lock_d_r <= ps_r.lock;
    end
  end
  assign rxe_ev = ps_r.rx_error && !rxerr_d_r;
  assign fcar_ev = ps_r.false_carrier && !fcar_d_r;

  // Force wins over the automatic algorithm; with force and crossover both off the pairs stay normal.
  always_comb begin
    if (ctl_r[PSS_B_CTL_XFRC]) begin
      xover = 1'b1; // see R3
    end else if (ctl_r[PSS_B_CTL_AXEN]) begin
      xover = ps_r.xover_swap; // see R3
    end else begin
      xover = 1'b0;
    end
  end

  assign qsd = ctl_r[PSS_B_CTL_SDQ] ? (ps_r.raw_sd && ps_r.lock) : ps_r.raw_sd; // see R7

  pss_stat_cell #(.LATCH_LOW(1'b0)) u_rxerr (
    .pclk(pclk), .presetn(presetn), .cond(rxe_ev), .clr(rc.rec), .q_r(l_rxerr) // see R4
  );
  pss_stat_cell #(.LATCH_LOW(1'b0)) u_fcar (
    .pclk(pclk), .presetn(presetn), .cond(fcar_ev), .clr(rc.fcc), .q_r(l_fcar) // see R6
  );
  pss_stat_cell #(.LATCH_LOW(1'b0)) u_pol (
    .pclk(pclk), .presetn(presetn), .cond(ps_r.polarity_inv), .clr(rc.ten), .q_r(l_pol) // see R5
  );
  // Signal detect and lock re-arm on a read of the summary register itself.
  pss_stat_cell #(.LATCH_LOW(1'b1)) u_sd (
    .pclk(pclk), .presetn(presetn), .cond(qsd), .clr(rd && (idx == PSS_IDX_SUM)),
    .q_r(l_sd) // see R7
  );
  pss_stat_cell #(.LATCH_LOW(1'b1)) u_lock (
    .pclk(pclk), .presetn(presetn), .cond(ps_r.lock), .clr(rd && (idx == PSS_IDX_SUM)),
    .q_r(l_lock) // see R8
  );
  pss_stat_cell #(.LATCH_LOW(1'b0)) u_page (
    .pclk(pclk), .presetn(presetn), .cond(ps_r.page_rx), .clr(rc.ner), .q_r(l_page) // see R9
  );
  pss_stat_cell #(.LATCH_LOW(1'b0)) u_rflt (
    .pclk(pclk), .presetn(presetn), .cond(ps_r.remote_fault), .clr(rc.bsr),
    .q_r(l_rflt) // see R10
  );
  // Jabber shares the basic status clear, so a summary read never touches it.
  pss_stat_cell #(.LATCH_LOW(1'b0)) u_jab (
    .pclk(pclk), .presetn(presetn), .cond(ps_r.jabber), .clr(rc.bsr), .q_r(l_jab) // see R11
  );

  always_comb begin
    sum = 16'h0000;
    sum[PSS_B_RSV15] = 1'b0; // see R1
    sum[PSS_B_XOVER] = xover; // see R2
    sum[PSS_B_RXERR] = l_rxerr;
    sum[PSS_B_POL] = l_pol;
    sum[PSS_B_FCAR] = l_fcar;
    sum[PSS_B_SDET] = l_sd;
    sum[PSS_B_LOCK] = l_lock;
    sum[PSS_B_PAGE] = l_page;
    sum[PSS_B_RSV7] = 1'b0; // see R1
    sum[PSS_B_RFLT] = l_rflt;
    sum[PSS_B_JAB] = l_jab;
  end

  // Saturating counters; a read returns the count and clears it, new events still win.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rec_cnt_r <= '0;
    end else if (rxe_ev && !(&rec_cnt_r)) begin
      rec_cnt_r <= rc.rec ? PSS_CNT_W'(1) : rec_cnt_r + PSS_CNT_W'(1);
    end else if (rc.rec) begin
      rec_cnt_r <= rxe_ev ? PSS_CNT_W'(1) : '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fcc_cnt_r <= '0;
    end else if (fcar_ev && !(&fcc_cnt_r)) begin
      fcc_cnt_r <= rc.fcc ? PSS_CNT_W'(1) : fcc_cnt_r + PSS_CNT_W'(1);
    end else if (rc.fcc) begin
      fcc_cnt_r <= fcar_ev ? PSS_CNT_W'(1) : '0;
    end
  end

  // Writes go only to control and mask; the summary and its sources drop them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r <= PSS_CTL_RST;
    end else if (wr && (idx == PSS_IDX_CTL)) begin
      ctl_r <= pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imk_r <= '0;
    end else if (wr && (idx == PSS_IDX_IMK)) begin
      imk_r <= pwdata[PSS_NEV-1:0];
    end
  end

  // Interrupt events: error, carrier, crossover change, lock loss, page, fault, jabber, polarity.
  always_comb begin
    ev_nxt = '0;
    ev_nxt[0] = rxe_ev;
    ev_nxt[1] = fcar_ev;
    ev_nxt[2] = xover != xover_d_r;
    ev_nxt[3] = lock_d_r && !ps_r.lock;
    ev_nxt[4] = ps_r.page_rx;
    ev_nxt[5] = ps_r.remote_fault;
    ev_nxt[6] = ps_r.jabber;
    ev_nxt[7] = ps_r.polarity_inv;
  end

  genvar g;
  generate
    for (g = 0; g < PSS_NEV; g++) begin : g_ist
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ist_r[g] <= 1'b0;
        end else if (ev_nxt[g]) begin
          ist_r[g] <= 1'b1;
        end else if (rd && (idx == PSS_IDX_IST)) begin
          ist_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(ist_r & imk_r);
    end
  end

  always_comb begin
    rd_nxt = PSS_RD_ZERO;
    ok_nxt = 1'b1;
    unique case (idx)
      PSS_IDX_SUM: rd_nxt[15:0] = sum; // see R12
      PSS_IDX_BSR: begin
        rd_nxt[PSS_B_BSR_RFLT] = l_rflt;
        rd_nxt[PSS_B_BSR_JAB] = l_jab;
      end
      PSS_IDX_NER: rd_nxt[PSS_B_NER_PAGE] = l_page;
      PSS_IDX_FCC: rd_nxt[PSS_CNT_W-1:0] = fcc_cnt_r;
      PSS_IDX_REC: rd_nxt[PSS_CNT_W-1:0] = rec_cnt_r;
      PSS_IDX_TEN: rd_nxt[PSS_B_TEN_POL] = l_pol;
      PSS_IDX_CTL: rd_nxt[2:0] = ctl_r;
      PSS_IDX_IST: rd_nxt[PSS_NEV-1:0] = ist_r;
      PSS_IDX_IMK: rd_nxt[PSS_NEV-1:0] = imk_r;
      PSS_IDX_SIG: rd_nxt[8:0] = ps_r;
      default: ok_nxt = 1'b0;
    endcase
  end

  // One wait state: pready rises in the second access cycle, with data registered.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (acc && !pready) begin
      pready <= 1'b1;
      prdata <= pwrite ? PSS_RD_ZERO : rd_nxt;
      pslverr <= !ok_nxt;
    end else begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end
  end
endmodule

//--- pss_summary_monitor.sv
// Checker for the summary status block, watching only its top-level ports.
// Assumes an APB master that holds paddr and pwrite through the pready cycle.
module pss_summary_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pss_pkg::PSS_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire pss_pkg::pss_phy_t phy_in,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq
);
  import pss_pkg::*;
  // Eight cycles of steady input cover the two sync flops, the latch and the read register.
  wire sum_ok = pready && psel && !pwrite &&
    (paddr[PSS_ADDR_W-1:PSS_BYTE_SHIFT] == PSS_IDX_SUM);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rsv; sum_ok |-> !prdata[PSS_B_RSV15] && !prdata[PSS_B_RSV7]; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_map; sum_ok |-> !pslverr && (prdata[31:16] == 16'h0); endproperty
  a_map: assert property (p_map) else $error("summary not mapped");
  property p_rxe; phy_in.rx_error [*8] ##0 sum_ok |-> prdata[PSS_B_RXERR]; endproperty
  a_rxe: assert property (p_rxe) else $error("rx error bit low");
  property p_fcar; phy_in.false_carrier [*8] ##0 sum_ok |-> prdata[PSS_B_FCAR]; endproperty
  a_fcar: assert property (p_fcar) else $error("false carrier bit low");
  property p_pol; phy_in.polarity_inv [*8] ##0 sum_ok |-> prdata[PSS_B_POL]; endproperty
  a_pol: assert property (p_pol) else $error("polarity bit low");
  sequence s_page; phy_in.page_rx [*8]; endsequence
  property p_page; s_page ##0 sum_ok |-> prdata[PSS_B_PAGE]; endproperty
  a_page: assert property (p_page) else $error("page bit low");
  property p_lock; !phy_in.lock [*8] ##0 sum_ok |-> !prdata[PSS_B_LOCK]; endproperty
  a_lock: assert property (p_lock) else $error("lock bit high");
  property p_sdet; !phy_in.raw_sd [*8] ##0 sum_ok |-> !prdata[PSS_B_SDET]; endproperty
  a_sdet: assert property (p_sdet) else $error("signal detect bit high");
  c_sum: cover property (sum_ok);
  c_err: cover property (pready && pslverr);
  c_irq: cover property ($rose(irq));
endmodule
bind pss_summary pss_summary_monitor mon_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .phy_in(phy_in),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

//--- pss_summary_tb.sv
// Self-checking bench for the summary status block.
// Assumes one APB wait state and phy inputs that take about three cycles to show.
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin miscompares++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module pss_summary_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pss_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [PSS_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic irq;
  logic er;
  pss_phy_t phy = '0;
  int compares = 0;
  int miscompares = 0;
  int cyc_n = 0;
  pss_summary dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .phy_in(phy), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq));
  initial begin
    forever #20 pclk = ~pclk;
  end
  task test_done;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task apb(input logic w, input logic [7:0] i, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rds(input logic [7:0] i);
    apb(1'b0, i, 32'h0);
  endtask
  task t_reset;
    rds(PSS_IDX_SUM);
    `CHK("sum_rst", PSS_RD_ZERO, rd)
    rds(PSS_IDX_CTL);
    `CHK("ctl_rst", 32'h1, rd)
    apb(1'b1, PSS_IDX_SUM, 32'hffff);
    rds(PSS_IDX_SUM);
    `CHK("sum_wr", PSS_RD_ZERO, rd)
    rds(8'h20);
    `CHK("unmapped", 1'b1, er)
  endtask
  // The masked phase proves the mask gates irq while the status bit is already set.
  task t_irq;
    apb(1'b1, PSS_IDX_IMK, 32'h0);
    phy.rx_error <= 1'b1;
    cyc(6);
    phy.rx_error <= 1'b0;
    cyc(2);
    `CHK("irq_mask", 1'b0, irq)
    apb(1'b1, PSS_IDX_IMK, 32'h1);
    cyc(2);
    `CHK("irq_on", 1'b1, irq)
    rds(PSS_IDX_IST);
    `CHK("ist", 1'b1, rd[0])
    cyc(2);
    `CHK("irq_off", 1'b0, irq)
  endtask
  task t_xover;
    for (int c = 0; c < 4; c++) begin
      for (int x = 0; x < 2; x++) begin
        apb(1'b1, PSS_IDX_CTL, 32'(c));
        phy.xover_swap <= x[0];
        cyc(5);
        rds(PSS_IDX_SUM);
        `CHK("xover", c[1] | (c[0] & x[0]), rd[PSS_B_XOVER])
      end
    end
    apb(1'b1, PSS_IDX_CTL, 32'(PSS_CTL_RST));
  endtask
  // The source read must return its own copy of the event before it clears the summary bit.
  task t_lh(input int p, input int s, input logic [7:0] c, input logic [31:0] sv);
    phy[p] <= 1'b1;
    cyc(6);
    rds(PSS_IDX_SUM);
    `CHK("lh_set", 1'b1, rd[s])
    phy[p] <= 1'b0;
    cyc(6);
    rds(PSS_IDX_SUM);
    `CHK("lh_hold", 1'b1, rd[s])
    rds(c);
    `CHK("lh_src", sv, rd)
    rds(PSS_IDX_SUM);
    `CHK("lh_clr", 1'b0, rd[s])
  endtask
  task drop_lock;
    phy.lock <= 1'b0;
    cyc(3);
    phy.lock <= 1'b1;
    cyc(6);
    rds(PSS_IDX_SUM);
  endtask
  task t_ll;
    phy.lock <= 1'b1;
    phy.raw_sd <= 1'b1;
    cyc(6);
    rds(PSS_IDX_SUM);
    rds(PSS_IDX_SUM);
    `CHK("ll_up", 2'h3, rd[PSS_B_SDET:PSS_B_LOCK])
    drop_lock();
    `CHK("ll_hold", 2'h2, rd[PSS_B_SDET:PSS_B_LOCK])
    rds(PSS_IDX_SUM);
    `CHK("ll_rearm", 2'h3, rd[PSS_B_SDET:PSS_B_LOCK])
    apb(1'b1, PSS_IDX_CTL, 32'h5);
    drop_lock();
    `CHK("ll_qual", 2'h0, rd[PSS_B_SDET:PSS_B_LOCK])
  endtask
  // A reset in mid-run must drop the fault latch and the control value.
  task t_mid_reset;
    phy.remote_fault <= 1'b1;
    cyc(6);
    phy.remote_fault <= 1'b0;
    cyc(2);
    rds(PSS_IDX_SUM);
    `CHK("rst_pre", 1'b1, rd[PSS_B_RFLT])
    presetn <= 1'b0;
    cyc(2);
    presetn <= 1'b1;
    rds(PSS_IDX_SUM);
    `CHK("rst_rflt", 1'b0, rd[PSS_B_RFLT])
    rds(PSS_IDX_CTL);
    `CHK("rst_ctl", 32'(PSS_CTL_RST), rd)
    rds(PSS_IDX_SIG);
    `CHK("rst_sig", 32'h118, rd)
  endtask
  always @(posedge pclk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 5000) begin
      miscompares++;
      test_done();
    end
  end
  initial begin
    cyc(8);
    presetn <= 1'b1;
    t_reset();
    t_irq();
    t_xover();
    t_lh(7, PSS_B_RXERR, PSS_IDX_REC, 32'h2);
    t_lh(6, PSS_B_FCAR, PSS_IDX_FCC, 32'h1);
    t_lh(5, PSS_B_POL, PSS_IDX_TEN, 32'h10);
    t_lh(2, PSS_B_PAGE, PSS_IDX_NER, 32'h2);
    t_lh(1, PSS_B_RFLT, PSS_IDX_BSR, 32'h10);
    t_lh(0, PSS_B_JAB, PSS_IDX_BSR, 32'h2);
    t_ll();
    t_mid_reset();
    test_done();
  end
endmodule
